// *** rtl/eii_regs.vh ***
// Constants for the external interrupt input front end.
// Assumes a single 40 MHz clock and no software-visible registers.
`ifndef EII_REGS_VH
`define EII_REGS_VH
`define EII_NMI_TYPE 8'h02
`define EII_NUM_MASK 4
`define EII_CLK_MHZ 40
`define EII_ACK_NS 25
`define EII_ACK_CYC ((`EII_ACK_NS * `EII_CLK_MHZ + 999) / 1000)
`define EII_SRC_NMI 3'h4
`define EII_SRC_NONE 3'h7
`endif

// *** rtl/eii_sync.v ***
// Two-flop synchroniser with edge detect from the second stage onward.
// Assumes the input may be asynchronous to mclk.
`timescale 1ns/100ps
module eii_sync (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Raw input and synchronised results
  input wire din,
  output reg sync_q,
  output wire rise
);
  reg meta_q;
  reg last_q;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  assign rise = sync_q & ~last_q;
endmodule // eii_sync

// *** rtl/eii_top.v ***
// External interrupt front end: one non-maskable input, four maskable pins.
// Assumes the core pulses inst_boundary between instructions and accepts
// the presented request with irq_accept.
`timescale 1ns/100ps
`include "eii_regs.vh"
module eii_top (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Non-maskable request pin
  input wire nmi_pin,
  // Maskable request pins (c and d are two-way)
  input wire mask_req_a,
  input wire mask_req_b,
  input wire mask_req_c,
  input wire mask_req_d,
  output reg ack_out_c,
  output reg ack_out_d,
  output reg ack_oe_c,
  output reg ack_oe_d,
  // Configuration
  input wire [3:0] level_mode,
  input wire [3:0] mask_en,
  input wire ack_mode_c,
  input wire ack_mode_d,
  input wire slave_mode,
  // Core side
  input wire inst_boundary,
  input wire irq_accept,
  output reg nmi_start_q,
  output reg irq_valid_q,
  output reg [7:0] irq_type_q,
  output reg [2:0] irq_src_q,
  output reg slave_req_q
);
  localparam ST_IDLE = 2'h0;
  localparam ST_NMI = 2'h1;
  localparam ST_MASK = 2'h2;
  localparam ST_ACK = 2'h3;

  wire [3:0] raw_req;
  wire [3:0] req_sync;
  wire [3:0] req_rise;
  wire [3:0] pin_is_in;
  wire nmi_sync;
  wire nmi_rise;
  reg nmi_pend_q;
  reg [3:0] pend_q;
  reg [3:0] req_act;
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [2:0] sel;
  reg [2:0] cur_q;
  reg [1:0] ack_cnt_q;
  integer k;
  reg ack_hit_c;
  reg ack_hit_d;
  wire go_nmi;
  wire go_mask;
  wire go_ack;
  wire take_now;
  // Pulse length held as a full word so the counter load is a plain slice
  localparam [31:0] ACK_CYC_W = `EII_ACK_CYC;

  assign raw_req = {mask_req_d, mask_req_c, mask_req_b, mask_req_a};
  // Pins c and d stop being requests when acking or in slave operation
  assign pin_is_in = {~(ack_mode_d | slave_mode),
                      ~(ack_mode_c | slave_mode), 2'h3};

  eii_sync u_nmi_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .din(nmi_pin),
    .sync_q(nmi_sync),
    .rise(nmi_rise)
  );

  genvar g;
  generate
    for (g = 0; g < `EII_NUM_MASK; g = g + 1) begin : g_req
      eii_sync u_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .din(raw_req[g]),
        .sync_q(req_sync[g]),
        .rise(req_rise[g])
      );
      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          pend_q[g] <= 1'b0;
        end else if (req_rise[g] & pin_is_in[g]) begin
          pend_q[g] <= 1'b1; // set wins over accept
        end else if (irq_accept && st_q == ST_MASK && cur_q == g) begin
          pend_q[g] <= 1'b0;
        end
      end
      always @* begin
        // Level mode follows the pin; edge mode uses the latched flag
        req_act[g] = pin_is_in[g] & mask_en[g] &
                     (level_mode[g] ? req_sync[g] : pend_q[g]);
      end
    end
  endgenerate

  // NMI latch: no enable term anywhere on this path
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_pend_q <= 1'b0;
    end else if (nmi_rise) begin
      nmi_pend_q <= 1'b1;
    end else if (irq_accept && st_q == ST_NMI) begin
      nmi_pend_q <= 1'b0;
    end
  end

  // Fixed priority: a over b over c over d
  always @* begin
    sel = `EII_SRC_NONE;
    for (k = `EII_NUM_MASK - 1; k >= 0; k = k - 1) begin
      if (req_act[k]) begin
        sel = k[2:0];
      end
    end
  end

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (inst_boundary && nmi_pend_q) begin
          st_d = ST_NMI;
        end else if (inst_boundary && sel != `EII_SRC_NONE) begin
          st_d = ST_MASK;
        end
      end
      ST_NMI: begin
        if (irq_accept) begin
          st_d = ST_IDLE;
        end
      end
      ST_MASK: begin
        if (irq_accept) begin
          st_d = ST_ACK;
        end
      end
      ST_ACK: begin
        if (ack_cnt_q == 2'h1) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Transitions the output stage reacts to
  assign go_nmi = st_q == ST_IDLE && st_d == ST_NMI;
  assign go_mask = st_q == ST_IDLE && st_d == ST_MASK;
  assign go_ack = st_q == ST_MASK && st_d == ST_ACK;
  assign take_now = irq_accept && (st_q == ST_NMI || st_q == ST_MASK);

  // Pin c answers request a and pin d answers request b; a pin that is an
  // acknowledge output can never be the request it would answer
  always @* begin
    ack_hit_c = 1'b0;
    ack_hit_d = 1'b0;
    if (go_ack) begin
      ack_hit_c = cur_q == 3'h0 && ack_mode_c && !slave_mode;
      // Slave operation acknowledges every taken maskable request on pin d; a taken NMI gets no pulse
      ack_hit_d = (cur_q == 3'h1 && ack_mode_d) || slave_mode;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
      cur_q <= `EII_SRC_NONE;
      ack_cnt_q <= 2'h0;
      nmi_start_q <= 1'b0;
      irq_valid_q <= 1'b0;
      irq_type_q <= 8'h00;
      irq_src_q <= `EII_SRC_NONE;
      ack_out_c <= 1'b1;
      ack_out_d <= 1'b1;
      ack_oe_c <= 1'b0;
      ack_oe_d <= 1'b0;
      slave_req_q <= 1'b0;
    end else begin
      st_q <= st_d;
      nmi_start_q <= 1'b0;
      // Slave operation forwards request a as the cascade request
      slave_req_q <= slave_mode & req_sync[0];
      ack_oe_c <= ack_mode_c & ~slave_mode;
      ack_oe_d <= ack_mode_d | slave_mode;
      if (go_nmi) begin
        nmi_start_q <= 1'b1;
        irq_valid_q <= 1'b1;
        irq_type_q <= `EII_NMI_TYPE;
        irq_src_q <= `EII_SRC_NMI;
        cur_q <= `EII_SRC_NMI;
      end else if (go_mask) begin
        irq_valid_q <= 1'b1;
        irq_type_q <= 8'h0C + {5'h00, sel};
        irq_src_q <= sel;
        cur_q <= sel;
      end else if (take_now) begin
        irq_valid_q <= 1'b0;
      end
      if (go_ack) begin
        ack_cnt_q <= ACK_CYC_W[1:0];
        ack_out_c <= ~ack_hit_c;
        ack_out_d <= ~ack_hit_d;
      end else if (ack_cnt_q != 2'h0) begin
        ack_cnt_q <= ack_cnt_q - 2'h1;
        if (ack_cnt_q == 2'h1) begin
          ack_out_c <= 1'b1;
          ack_out_d <= 1'b1;
        end
      end
    end
  end
endmodule // eii_top

// *** test/eii_src.sv ***
// Model of one external request source.
// Assumes fire and done are one-cycle strobes in the mclk domain.
`timescale 1ns/100ps
module eii_src (
  // Clock
  input wire mclk,
  // Start and release strobes
  input wire fire,
  input wire done,
  // Request line
  output reg req
);
  initial req = 1'b0;
  // Held until served, so never shorter than a clock
  always @(posedge mclk) begin
    if (fire)
      req <= 1'b1;
    else if (done)
      req <= 1'b0;
  end
endmodule // eii_src

// *** test/eii_chk_asserts.sv ***
// Checker for the external interrupt front end.
// Bound to eii_top; sees its ports only.
`timescale 1ns/100ps
module eii_chk (
  // Clock and reset
  input logic mclk,
  input logic arst_n,
  // Inputs
  input logic nmi_pin,
  input logic inst_boundary,
  input logic irq_accept,
  input logic ack_mode_d,
  input logic slave_mode,
  // Outputs
  input logic nmi_start_q,
  input logic irq_valid_q,
  input logic [7:0] irq_type_q,
  input logic [2:0] irq_src_q,
  input logic ack_out_d,
  input logic ack_oe_d
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_quiet;
    !nmi_start_q [*3];
  endsequence
  property p_type;
    nmi_start_q |-> irq_type_q == 8'h02 && irq_src_q == 3'h4;
  endproperty
  a_type: assert property (p_type)
    else $error("nmi type");
  property p_sync;
    $rose(nmi_pin) |-> s_quiet;
  endproperty
  a_sync: assert property (p_sync)
    else $error("nmi early");
  property p_bnd;
    nmi_start_q |-> $past(inst_boundary);
  endproperty
  a_bnd: assert property (p_bnd)
    else $error("nmi off boundary");
  property p_pulse;
    nmi_start_q |=> !nmi_start_q;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("nmi pulse");
  property p_hold;
    irq_valid_q && !irq_accept |=> irq_valid_q;
  endproperty
  a_hold: assert property (p_hold)
    else $error("valid lost");
  property p_drop;
    irq_valid_q && irq_accept |=> !irq_valid_q;
  endproperty
  a_drop: assert property (p_drop)
    else $error("valid stuck");
  property p_slave;
    slave_mode |=> ack_oe_d;
  endproperty
  a_slave: assert property (p_slave)
    else $error("slave ack");
  property p_idle;
    !ack_mode_d && !slave_mode |=> ack_out_d && !ack_oe_d;
  endproperty
  a_idle: assert property (p_idle)
    else $error("ack idle");
endmodule // eii_chk
bind eii_top eii_chk i_eii_chk (.mclk, .arst_n, .nmi_pin, .inst_boundary,
  .irq_accept, .ack_mode_d, .slave_mode, .nmi_start_q, .irq_valid_q,
  .irq_type_q, .irq_src_q, .ack_out_d, .ack_oe_d);

// *** test/tb_eii_top.sv ***
// Self-checking bench for the external interrupt front end.
// Plays the core with random boundaries and accepts.
`timescale 1ns/100ps
module tb_eii_top;
  logic mclk = 0, arst_n = 0, fire_n = 0, fire_a = 0, vq = 0, x;
  logic mask_req_b = 0, mask_req_c = 0, mask_req_d = 0;
  logic ack_mode_c = 1, ack_mode_d = 0, slave_mode = 0;
  logic inst_boundary = 0, irq_accept = 0;
  logic [3:0] level_mode = 4'h0, mask_en = 4'hF;
  logic [2:0] gap = 3'h0;
  logic [10:0] exp_q[$];
  wire nmi_pin, mask_req_a, ack_out_c, ack_out_d, ack_oe_c, ack_oe_d;
  wire nmi_start_q, irq_valid_q, slave_req_q;
  wire [7:0] irq_type_q;
  wire [2:0] irq_src_q;
  int miscompares = 0, checked = 0;
  logic ack_c_exp = 1, ack_d_exp = 1, oe_c_exp = 0, slv_exp = 0;
  logic a1 = 0, a2 = 0;
  eii_top i_eii_top (.mclk, .arst_n, .nmi_pin, .mask_req_a, .mask_req_b,
    .mask_req_c, .mask_req_d, .ack_out_c, .ack_out_d, .ack_oe_c,
    .ack_oe_d, .level_mode, .mask_en, .ack_mode_c, .ack_mode_d,
    .slave_mode, .inst_boundary, .irq_accept, .nmi_start_q, .irq_valid_q,
    .irq_type_q, .irq_src_q, .slave_req_q);
  eii_src i_eii_src_n (.mclk, .fire(fire_n), .done(nmi_start_q),
    .req(nmi_pin));
  eii_src i_eii_src_a (.mclk, .fire(fire_a),
    .done(irq_accept && irq_src_q == 3'h0), .req(mask_req_a));
  always #12.5 mclk = ~mclk;
  task chk(input string n, input [10:0] s, e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h saw %h", n, e, s);
    end
  endtask
  task end_sim;
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task pulse(input n, a, input [10:0] e);
    exp_q.push_back(e);
    fire_n <= n;
    fire_a <= a;
    @(posedge mclk);
    fire_n <= 0;
    fire_a <= 0;
  endtask
  task drain;
    int i;
    for (i = 0; i < 400 && (exp_q.size() > 0 || irq_valid_q); i++)
      @(posedge mclk);
    if (i == 400) begin
      miscompares++;
      end_sim;
    end else begin
      repeat (20) @(posedge mclk);
    end
  endtask
  // Core: random boundaries, quiet gap after each accept
  always @(posedge mclk) begin
    x = irq_valid_q && !irq_accept && $urandom % 2;
    irq_accept <= x;
    gap <= x ? 3'h7 : gap - (gap != 0);
    inst_boundary <= gap == 0 && $urandom % 3 == 0;
    if (x && irq_src_q == 3'h1) mask_req_b <= 0;
    if (x && irq_src_q == 3'h2) mask_req_c <= 0;
    // Expected pin levels, from what the core side saw at this edge
    ack_c_exp <= !(irq_valid_q && irq_accept && irq_src_q == 3'h0 &&
      ack_mode_c && !slave_mode);
    ack_d_exp <= !(irq_valid_q && irq_accept && irq_src_q < 3'h4 &&
      ((irq_src_q == 3'h1 && ack_mode_d) || slave_mode));
    oe_c_exp <= arst_n && ack_mode_c && !slave_mode;
    a1 <= mask_req_a;
    a2 <= a1;
    slv_exp <= arst_n && slave_mode && a2;
  end
  always @(negedge mclk) begin
    if (irq_valid_q && !vq)
      chk("irq", {irq_type_q, irq_src_q},
        exp_q.size() ? exp_q.pop_front() : 11'h7FF);
    chk("ack_c", {10'h000, ack_out_c}, {10'h000, ack_c_exp});
    chk("ack_d", {10'h000, ack_out_d}, {10'h000, ack_d_exp});
    chk("oe_c", {10'h000, ack_oe_c}, {10'h000, oe_c_exp});
    chk("slv", {10'h000, slave_req_q}, {10'h000, slv_exp});
    vq = irq_valid_q;
  end
  initial begin
    x = $urandom(32'h07CE07D9);
    repeat (8) @(posedge mclk);
    arst_n <= 1;
    @(posedge mclk);
    pulse(1, 0, {8'h02, 3'h4});
    drain;
    mask_en <= 4'h0;
    pulse(1, 0, {8'h02, 3'h4});
    drain;
    mask_en <= 4'hF;
    exp_q.push_back({8'h02, 3'h4});
    pulse(1, 1, {8'h0C, 3'h0});
    drain;
    level_mode <= 4'h2;
    mask_req_b <= 1;
    exp_q.push_back({8'h0D, 3'h1});
    drain;
    slave_mode <= 1;
    mask_req_c <= 1;
    pulse(0, 1, {8'h0C, 3'h0});
    drain;
    chk("oe_d", {10'h000, ack_oe_d}, 11'h001);
    slave_mode <= 0;
    drain;
    mask_req_c <= 0;
    ack_mode_c <= 0;
    repeat (5) @(posedge mclk);
    mask_req_c <= 1;
    exp_q.push_back({8'h0E, 3'h2});
    drain;
    end_sim;
  end
endmodule // tb_eii_top
